// [hw/sdi_io_interlock.sv]
// Discrete I/O, fault interlock and brake sequencing of a servo drive
// Summary of operation
// - Drive-ready only when powered, fault-free, bus charged
// - Any fault drops drive-ready, shows fault code
// - High bus fault clears only after bus discharged
// - Over-temperature holds until cool; others software-clearable
// - No motor power while any fault stands
// - Stop input low disables, or commands zero in all but torque mode
// - Four inputs; input four shares pin output four
// - Input one forward limit, two reverse
// - Limit in motion modes stops, raises error
// - Limit flag clears on a register write after input conducts again
// - E-stop low: fault, power off, fault event
// - Quick stop torque: alarm, enabled, torque accepted
// - Quick stop velocity/position: alarm, zero speed
// - Quick stop suppresses missing-phase when input two low
// - Five outputs; three brake, four ready, five reference
// - Brake output high releases brake
// - Delays between power and brake, both directions
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sdi_io_interlock
  import sdi_pkg::*;
(
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  input wire logic forward_limit_input, // Pin, high while conducting
  input wire logic reverse_limit_input, // Pin, high while conducting
  input wire logic stop_input, // Pin, high while conducting
  input wire logic shared_input_four_in, // Shared pin level
  output logic shared_input_four_out, // Shared pin drive level
  output logic shared_input_four_oe, // High while driving the pin
  input wire logic bus_charged, // Power stage: bus charged
  input wire logic bus_over_limit, // Power stage: bus above fault limit
  input wire logic main_power_on, // Power stage: main input power present
  input wire logic motor_hot, // Motor temperature sensor
  input wire logic drive_fault_in, // Other internal drive fault
  input wire logic encoder_ref_in, // Encoder zero reference
  output logic [4:0] out_pins, // Discrete outputs one to five
  output logic motor_power_en, // Power stage enable
  output logic zero_command, // Command zero speed
  output logic torque_cmd_accept, // Torque commands accepted
  output logic motion_stop, // Commanded motion stopped
  output logic fwd_inhibit, // Motion toward forward limit blocked
  output logic rev_inhibit, // Motion toward reverse limit blocked
  output logic phase_check_en, // Missing-phase detection enabled
  output logic [7:0] fault_code // Status display code, zero if none
);

  // Synchronisers for every pin and foreign-domain level
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw;
  assign raw = {encoder_ref_in, drive_fault_in, motor_hot, main_power_on, bus_over_limit,
                bus_charged, shared_input_four_in, stop_input, forward_limit_input};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  // Reverse limit kept separately so the vector stays one per pin above
  logic rev_a;
  logic rev_b;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rev_a <= 1'b0;
      rev_b <= 1'b0;
    end else begin
      rev_a <= reverse_limit_input;
      rev_b <= rev_a;
    end
  end

  logic fwd_s, stop_s, in4_s, charged_s, over_s, mains_s, hot_s, dflt_s, encref_s;
  assign fwd_s = sync_b[0];
  assign stop_s = sync_b[1];
  assign in4_s = sync_b[2];
  assign charged_s = sync_b[3];
  assign over_s = sync_b[4];
  assign mains_s = sync_b[5];
  assign hot_s = sync_b[6];
  assign dflt_s = sync_b[7];
  assign encref_s = sync_b[8];

  // Registers
  logic [31:0] config_r;
  logic [4:0] gp_out;
  logic [FLT_W-1:0] fault;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic [1:0] limit_flag; // bit0 forward, bit1 reverse
  logic [DLY_W-1:0] brk_on_dly;
  logic [DLY_W-1:0] brk_off_dly;
  logic [1:0] motion_dir; // bit0 moving forward, bit1 moving reverse

  sdi_stop_e stop_mode;
  sdi_axis_e axis_mode;
  logic limit_en, brake_en, ready_en, encref_en, enable_req;
  assign limit_en = config_r[CFG_LIMIT_EN];
  assign stop_mode = sdi_stop_e'(config_r[CFG_STOP_LO +: 2]);
  assign axis_mode = sdi_axis_e'(config_r[CFG_AXIS_LO +: 2]);
  assign brake_en = config_r[CFG_BRAKE_EN];
  assign ready_en = config_r[CFG_READY_EN];
  assign encref_en = config_r[CFG_ENCREF_EN];
  assign enable_req = config_r[CFG_ENABLE_REQ];

  logic wr_cfg, wr_fclr, wr_fset, wr_evt;
  assign wr_cfg = wr_en && (addr == ADDR_CONFIG);
  assign wr_fset = wr_en && (addr == ADDR_FAULT_SET);
  assign wr_fclr = wr_en && (addr == ADDR_FAULT_CLR);
  assign wr_evt = wr_en && (addr == ADDR_EVT_STATUS);

  // Plain configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      config_r <= CONFIG_RST;
      gp_out <= 5'h00;
      evt_mask <= 4'h0;
      brk_on_dly <= DLY_RST;
      brk_off_dly <= DLY_RST;
      motion_dir <= 2'h0;
    end else if (wr_en) begin
      if (wr_cfg) begin
        config_r <= wdata;
      end else if (addr == ADDR_GP_OUT) begin
        gp_out <= wdata[4:0];
      end else if (addr == ADDR_EVT_MASK) begin
        evt_mask <= wdata[EVT_W-1:0];
      end else if (addr == ADDR_BRK_ON_DLY) begin
        brk_on_dly <= wdata[DLY_W-1:0];
      end else if (addr == ADDR_BRK_OFF_DLY) begin
        brk_off_dly <= wdata[DLY_W-1:0];
      end else if (addr == ADDR_MOTION) begin
        motion_dir <= wdata[1:0];
      end
    end
  end

  // Stop input causes, not conducting (low) means asserted
  logic estop_act, qstop_act;
  assign estop_act = (stop_mode == SDI_STOP_ESTOP) && !stop_s;
  assign qstop_act = (stop_mode == SDI_STOP_QUICK) && !stop_s;

  // Fault sources; hardware sets win over a software clear
  logic [FLT_W-1:0] fault_src;
  logic [FLT_W-1:0] clr_ok;
  assign fault_src = {dflt_s, estop_act, hot_s, over_s};
  always_comb begin
    clr_ok = 4'h0;
    clr_ok[FLT_HIGH_BUS] = !mains_s && !over_s;
    clr_ok[FLT_OVER_TEMP] = !hot_s;
    clr_ok[FLT_ESTOP] = !estop_act;
    clr_ok[FLT_OTHER] = !dflt_s;
  end
  logic [FLT_W-1:0] next_fault;
  assign next_fault = (fault & ~(wr_fclr ? (wdata[FLT_W-1:0] & clr_ok) : 4'h0)) | fault_src
                      | (wr_fset ? wdata[FLT_W-1:0] : 4'h0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault <= 4'h0;
    end else begin
      fault <= next_fault;
    end
  end
  logic any_fault;
  assign any_fault = |fault;

  // Travel limits: latch while the input opens, clear by a limit register write once conducting, or whenever limits are disabled
  logic [1:0] lim_open;
  assign lim_open = {!rev_b, !fwd_s};
  logic motion_mode;
  assign motion_mode = (axis_mode != SDI_AXIS_TORQUE);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      limit_flag <= 2'h0;
    end else if (!limit_en) begin
      limit_flag <= 2'h0;
    end else begin
      limit_flag <= (limit_flag & ~((wr_en && addr == ADDR_LIMIT) ? (wdata[1:0] & ~lim_open)
                    : 2'h0)) | lim_open;
    end
  end

  // Power and brake sequencing with tick-based delays
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  sdi_pwr_e pwr_state;
  sdi_pwr_e next_pwr_state;
  logic [DLY_W-1:0] dly_cnt;
  logic want_power;
  assign want_power = enable_req && !any_fault && charged_s;

  // Power-down from a fault skips the brake wait: power must go now
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      SDI_PWR_OFF: begin
        if (want_power) begin
          next_pwr_state = SDI_PWR_ON_WAIT;
        end
      end
      SDI_PWR_ON_WAIT: begin
        if (any_fault) begin
          next_pwr_state = SDI_PWR_OFF;
        end else if (!want_power) begin
          next_pwr_state = SDI_PWR_OFF_WAIT;
        end else if (dly_cnt == '0) begin
          next_pwr_state = SDI_PWR_RUN;
        end
      end
      SDI_PWR_RUN: begin
        if (any_fault) begin
          next_pwr_state = SDI_PWR_OFF;
        end else if (!want_power) begin
          next_pwr_state = SDI_PWR_OFF_WAIT;
        end
      end
      SDI_PWR_OFF_WAIT: begin
        if (any_fault || dly_cnt == '0) begin
          next_pwr_state = SDI_PWR_OFF;
        end
      end
      default: next_pwr_state = SDI_PWR_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_state <= SDI_PWR_OFF;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // Delay counter loads on entry and counts down on each tick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dly_cnt <= '0;
    end else if (pwr_state == SDI_PWR_OFF && next_pwr_state == SDI_PWR_ON_WAIT) begin
      dly_cnt <= brk_on_dly;
    end else if (pwr_state != SDI_PWR_OFF_WAIT && next_pwr_state == SDI_PWR_OFF_WAIT) begin
      dly_cnt <= brk_off_dly;
    end else if (tick && dly_cnt != '0) begin
      dly_cnt <= dly_cnt - 1'b1;
    end
  end

  // Events: sticky, write one to clear, a new event wins
  logic [EVT_W-1:0] evt_set;
  logic [1:0] lim_motion;
  assign lim_motion = (limit_en && motion_mode) ? (lim_open & ~limit_flag) : 2'h0;
  assign evt_set = {|(lim_open & ~limit_flag & {2{limit_en}}), |lim_motion, qstop_act,
                    |(next_fault & ~fault)};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_status <= 4'h0;
    end else begin
      evt_status <= (evt_status & ~(wr_evt ? wdata[EVT_W-1:0] : 4'h0)) | evt_set;
    end
  end

  // Registered outputs
  logic powered, running;
  assign powered = (pwr_state != SDI_PWR_OFF) && !any_fault;
  assign running = (pwr_state == SDI_PWR_RUN);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_pins <= 5'h00;
      shared_input_four_out <= 1'b0;
      shared_input_four_oe <= 1'b0;
      motor_power_en <= 1'b0;
      irq <= 1'b0;
    end else begin
      out_pins[1:0] <= gp_out[1:0];
      out_pins[2] <= brake_en ? (running && !any_fault && !estop_act) : gp_out[2];
      out_pins[3] <= ready_en ? (powered && charged_s) : gp_out[3];
      out_pins[4] <= encref_en ? encref_s : gp_out[4];
      // Pin four is an input unless drive-ready or a set output drives it
      shared_input_four_out <= ready_en ? (powered && charged_s) : gp_out[3];
      shared_input_four_oe <= ready_en || gp_out[3];
      motor_power_en <= powered && !estop_act;
      irq <= |(evt_status & evt_mask);
    end
  end

  // Motion command outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_command <= 1'b0;
      torque_cmd_accept <= 1'b0;
      motion_stop <= 1'b0;
      fwd_inhibit <= 1'b0;
      rev_inhibit <= 1'b0;
      phase_check_en <= 1'b1;
      fault_code <= 8'h00;
    end else begin
      zero_command <= qstop_act && motion_mode;
      torque_cmd_accept <= powered && (axis_mode == SDI_AXIS_TORQUE);
      motion_stop <= (limit_en && motion_mode && |lim_open) || (|(limit_flag & motion_dir));
      fwd_inhibit <= limit_en && (limit_flag[0] || lim_open[0]);
      rev_inhibit <= limit_en && (limit_flag[1] || lim_open[1]);
      phase_check_en <= !((stop_mode == SDI_STOP_QUICK) && !rev_b);
      fault_code <= {4'h0, fault};
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (addr == ADDR_CONFIG) begin
        rdata <= config_r;
      end else if (addr == ADDR_GP_OUT) begin
        rdata <= {27'h0, gp_out};
      end else if (addr == ADDR_FAULT) begin
        rdata <= {28'h0, fault};
      end else if (addr == ADDR_INPUTS) begin
        rdata <= {25'h0, pwr_state, in4_s, stop_s, rev_b, fwd_s};
      end else if (addr == ADDR_EVT_STATUS) begin
        rdata <= {28'h0, evt_status};
      end else if (addr == ADDR_EVT_MASK) begin
        rdata <= {28'h0, evt_mask};
      end else if (addr == ADDR_LIMIT) begin
        rdata <= {30'h0, limit_flag};
      end else if (addr == ADDR_BRK_ON_DLY) begin
        rdata <= {16'h0, brk_on_dly};
      end else if (addr == ADDR_BRK_OFF_DLY) begin
        rdata <= {16'h0, brk_off_dly};
      end else if (addr == ADDR_MOTION) begin
        rdata <= {30'h0, motion_dir};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// [hw/sdi_pkg.sv]
// Constants, register map and types of the servo drive I/O interlock block
package sdi_pkg;
  // Clock rate and the brake-delay time tick
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int TICK_W = 16;
  localparam int DLY_W = 16;

  // Register addresses (byte offsets, 32-bit words)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_GP_OUT = 8'h04;
  localparam logic [7:0] ADDR_FAULT_SET = 8'h08;
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h0c;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] ADDR_INPUTS = 8'h14;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h1c;
  localparam logic [7:0] ADDR_LIMIT = 8'h20;
  localparam logic [7:0] ADDR_BRK_ON_DLY = 8'h24;
  localparam logic [7:0] ADDR_BRK_OFF_DLY = 8'h28;
  localparam logic [7:0] ADDR_MOTION = 8'h2c;

  // Configuration register fields
  localparam int CFG_LIMIT_EN = 0;
  localparam int CFG_STOP_LO = 1;
  localparam int CFG_BRAKE_EN = 3;
  localparam int CFG_READY_EN = 4;
  localparam int CFG_ENCREF_EN = 5;
  localparam int CFG_AXIS_LO = 6;
  localparam int CFG_ENABLE_REQ = 8;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

  // Fault bits
  localparam int FLT_W = 4;
  localparam int FLT_HIGH_BUS = 0;
  localparam int FLT_OVER_TEMP = 1;
  localparam int FLT_ESTOP = 2;
  localparam int FLT_OTHER = 3;

  // Event bits
  localparam int EVT_W = 4;
  localparam int EVT_FAULT = 0;
  localparam int EVT_ALARM = 1;
  localparam int EVT_MOTION_ERR = 2;
  localparam int EVT_LIMIT = 3;

  localparam logic [DLY_W-1:0] DLY_RST = 16'h0000;

  // Stop input usage
  typedef enum logic [1:0] {
    SDI_STOP_GP = 2'b00,
    SDI_STOP_ESTOP = 2'b01,
    SDI_STOP_QUICK = 2'b10
  } sdi_stop_e;

  // Axis mode
  typedef enum logic [1:0] {
    SDI_AXIS_TORQUE = 2'b00,
    SDI_AXIS_VELOCITY = 2'b01,
    SDI_AXIS_POSITION = 2'b10,
    SDI_AXIS_OUTPUT = 2'b11
  } sdi_axis_e;

  // Power and brake sequence
  typedef enum logic [2:0] {
    SDI_PWR_OFF = 3'b000,
    SDI_PWR_ON_WAIT = 3'b001,
    SDI_PWR_RUN = 3'b010,
    SDI_PWR_OFF_WAIT = 3'b011
  } sdi_pwr_e;
endpackage

// [verification/sdi_io_interlock_chk.sv]
// Port assertions for the servo drive I/O interlock
`timescale 1ns/1ps
module sdi_io_interlock_chk (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic rd_en, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic forward_limit_input, // Forward pin
  input wire logic reverse_limit_input, // Reverse pin
  input wire logic bus_charged, // Bus state
  input wire logic [4:0] out_pins, // Outputs
  input wire logic motor_power_en, // Power enable
  input wire logic zero_command, // Zero speed
  input wire logic torque_cmd_accept, // Torque accepted
  input wire logic fwd_inhibit, // Forward block
  input wire logic rev_inhibit, // Reverse block
  input wire logic phase_check_en, // Phase check
  input wire logic [7:0] fault_code // Display code
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Read data only stands in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_RESET_OUT: assert property ($fell(rst) |-> out_pins == 5'h00 && !motor_power_en
    && phase_check_en && fault_code == 8'h00) else $error("outputs not at reset values");
  AST_FAULT_NO_POWER: assert property ((fault_code != 8'h00) [*2] |-> !motor_power_en)
    else $error("motor power with a fault standing");
  AST_FAULT_DROPS_READY: assert property ((fault_code != 8'h00) [*3] |-> !out_pins[3])
    else $error("ready output held during fault");
  AST_BUS_READY: assert property ((!bus_charged) [*4] |-> !out_pins[3])
    else $error("ready output with bus discharged");
  // Brake may only lift with holding torque present, and power drops only with brake set
  AST_BRAKE_AFTER_POWER: assert property ($rose(out_pins[2]) |->
    motor_power_en && $past(motor_power_en)) else $error("brake released early");
  AST_POWER_AFTER_BRAKE: assert property ($fell(motor_power_en) |-> !out_pins[2])
    else $error("power removed with brake released");
  AST_PHASE_KEEP: assert property (reverse_limit_input [*4] |-> phase_check_en)
    else $error("phase check off with input two high");
  AST_ZERO_VS_TORQUE: assert property (!(zero_command && torque_cmd_accept))
    else $error("zero command while torque accepted");
  AST_FWD_CLEAR: assert property ($fell(fwd_inhibit) |-> $past(forward_limit_input, 4))
    else $error("forward flag cleared while blocked");
  AST_REV_CLEAR: assert property ($fell(rev_inhibit) |-> $past(reverse_limit_input, 4))
    else $error("reverse flag cleared while blocked");

  // Main scenarios reached
  COV_BRAKE: cover property ($rose(out_pins[2]));
  COV_LIMIT: cover property ($rose(fwd_inhibit));
  COV_PHASE: cover property ($fell(phase_check_en));
endmodule

bind sdi_io_interlock sdi_io_interlock_chk chk_u (.sys_clk, .rst, .rd_en, .rdata,
  .forward_limit_input, .reverse_limit_input, .bus_charged, .out_pins, .motor_power_en,
  .zero_command, .torque_cmd_accept, .fwd_inhibit, .rev_inhibit, .phase_check_en,
  .fault_code);

// [verification/sdi_power_model.sv]
// Behavioural model of the main power stage and motor thermal sensor
`timescale 1ns/1ps
module sdi_power_model (
  input wire logic sys_clk, // Clock
  input wire logic main_cmd, // Contactor closed
  input wire logic ovl_cmd, // Supply surge on the bus
  input wire logic hot_cmd, // Motor heating
  output logic main_power_on = 1'b0, // Main input power
  output logic bus_charged, // Bus capacitors charged
  output logic bus_over_limit = 1'b0, // Bus above fault limit
  output logic motor_hot = 1'b0 // Motor too hot
);
  logic [2:0] charge = 3'h0;
  // Contactor and sensor follow their causes one cycle late
  always_ff @(posedge sys_clk) begin
    main_power_on <= main_cmd;
    motor_hot <= hot_cmd;
  end
  // Bus charges over a few cycles, so readiness lags power
  always_ff @(posedge sys_clk) begin
    if (main_power_on && charge != 3'h7) begin
      charge <= charge + 3'h1;
    end else if (!main_power_on && charge != 3'h0) begin
      charge <= charge - 3'h1;
    end
  end
  assign bus_charged = charge > 3'h3;
  // A high bus cannot bleed down while main power still feeds it
  always_ff @(posedge sys_clk) begin
    bus_over_limit <= ovl_cmd || (bus_over_limit && main_power_on);
  end
endmodule

// [verification/sdi_io_interlock_bench.sv]
// Self-checking bench for the servo drive I/O interlock
`timescale 1ns/1ps
module sdi_io_interlock_bench;
  import sdi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic fwd = 1'b1;
  logic rev = 1'b1;
  logic stp = 1'b1;
  logic enc = 1'b0;
  logic ext4 = 1'b0;
  logic dflt = 1'b0;
  logic main_cmd = 1'b0;
  logic ovl_cmd = 1'b0;
  logic hot_cmd = 1'b0;
  logic [31:0] rdata, v;
  logic irq, pin4, drive_ok_output, oe4, charged, over, mains, hot;
  logic [4:0] out_pins;
  logic pwr_en, zero_cmd, tq_acc, mstop, fwd_inh, rev_inh, phase_en;
  logic [7:0] fault_code;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #10 sys_clk = ~sys_clk;
  // Shared pin level: the block's drive wins while its enable is high
  assign pin4 = oe4 ? drive_ok_output : ext4;

  sdi_io_interlock dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .forward_limit_input(fwd),
    .reverse_limit_input(rev), .stop_input(stp), .shared_input_four_in(pin4),
    .shared_input_four_out(drive_ok_output), .shared_input_four_oe(oe4), .bus_charged(charged),
    .bus_over_limit(over), .main_power_on(mains), .motor_hot(hot), .drive_fault_in(dflt),
    .encoder_ref_in(enc), .out_pins(out_pins), .motor_power_en(pwr_en),
    .zero_command(zero_cmd), .torque_cmd_accept(tq_acc), .motion_stop(mstop),
    .fwd_inhibit(fwd_inh), .rev_inhibit(rev_inh), .phase_check_en(phase_en),
    .fault_code(fault_code));

  sdi_power_model power_u (.sys_clk(sys_clk), .main_cmd(main_cmd), .ovl_cmd(ovl_cmd),
    .hot_cmd(hot_cmd), .main_power_on(mains), .bus_charged(charged),
    .bus_over_limit(over), .motor_hot(hot));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // Read data is taken one cycle after the strobe, once it has settled
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
    chk32(v & m, e);
  endtask
  task automatic pins(input logic f, input logic r, input logic s, input logic e);
    @(posedge sys_clk);
    fwd <= f;
    rev <= r;
    stp <= s;
    enc <= e;
  endtask
  task automatic pwr(input logic m, input logic o, input logic h);
    @(posedge sys_clk);
    main_cmd <= m;
    ovl_cmd <= o;
    hot_cmd <= h;
  endtask
  // Pins pass a two-stage synchroniser, so allow several edges
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wt(1);
    // Reset values and an unmapped address
    rchk(ADDR_CONFIG, '1, CONFIG_RST);
    rchk(ADDR_BRK_ON_DLY, '1, 32'h0);
    rchk(8'h3c, '1, 32'h0);
    chk1(phase_en, 1'b1);
    // Power up, brake release with zero delay, outputs in their special roles
    pwr(1'b1, 1'b0, 1'b0);
    wr(ADDR_CONFIG, 32'h179);
    wr(ADDR_GP_OUT, 32'h3);
    wt(12);
    chk1(pwr_en, 1'b1);
    chk32({27'h0, out_pins}, 32'h0f);
    chk1(oe4 & drive_ok_output, 1'b1);
    rchk(ADDR_INPUTS, 32'h7f, 32'h2f);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    wt(5);
    chk1(out_pins[4], 1'b1);
    // Forced fault drops power, brake and ready; interrupt raised, masked, cleared
    wr(ADDR_EVT_MASK, 32'h1);
    wr(ADDR_FAULT_SET, 32'h8);
    wt(4);
    chk1(pwr_en, 1'b0);
    chk32({27'h0, out_pins}, 32'h13);
    chk1(drive_ok_output, 1'b0);
    chk32({24'h0, fault_code}, 32'h08);
    chk1(irq, 1'b1);
    wr(ADDR_EVT_MASK, 32'h0);
    wt(3);
    chk1(irq, 1'b0);
    wr(ADDR_FAULT_CLR, 32'h8);
    rchk(ADDR_FAULT, '1, 32'h0);
    wr(ADDR_EVT_STATUS, 32'h1);
    rchk(ADDR_EVT_STATUS, 32'h1, 32'h0);
    wt(12);
    chk1(pwr_en, 1'b1);
    // Over-temperature holds until the motor cools
    pwr(1'b1, 1'b0, 1'b1);
    wt(6);
    wr(ADDR_FAULT_CLR, 32'h2);
    rchk(ADDR_FAULT, '1, 32'h2);
    pwr(1'b1, 1'b0, 1'b0);
    wt(6);
    wr(ADDR_FAULT_CLR, 32'h2);
    rchk(ADDR_FAULT, '1, 32'h0);
    // Another internal fault clears only once its cause is gone
    @(posedge sys_clk);
    dflt <= 1'b1;
    wt(6);
    wr(ADDR_FAULT_CLR, 32'h8);
    rchk(ADDR_FAULT, '1, 32'h8);
    @(posedge sys_clk);
    dflt <= 1'b0;
    wt(6);
    wr(ADDR_FAULT_CLR, 32'h8);
    rchk(ADDR_FAULT, '1, 32'h0);
    // High bus clears only with mains off and the bus bled down
    pwr(1'b1, 1'b1, 1'b0);
    pwr(1'b1, 1'b0, 1'b0);
    wt(6);
    wr(ADDR_FAULT_CLR, 32'h1);
    rchk(ADDR_FAULT, '1, 32'h1);
    pwr(1'b0, 1'b0, 1'b0);
    wt(8);
    wr(ADDR_FAULT_CLR, 32'h1);
    rchk(ADDR_FAULT, '1, 32'h0);
    pwr(1'b1, 1'b0, 1'b0);
    wt(12);
    chk1(pwr_en, 1'b1);
    // Emergency stop: fault, power off, no restart until cleared
    wr(ADDR_CONFIG, 32'h17a);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    wt(6);
    chk1(pwr_en, 1'b0);
    rchk(ADDR_FAULT, '1, 32'h4);
    rchk(ADDR_EVT_STATUS, 32'h1, 32'h1);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    wt(12);
    chk1(pwr_en, 1'b0);
    wr(ADDR_FAULT_CLR, 32'h4);
    wr(ADDR_EVT_STATUS, 32'hf);
    wt(12);
    chk1(pwr_en, 1'b1);
    // Quick stop in torque, velocity and position modes
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONFIG, 32'h13c | 32'(i << 6));
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      wt(6);
      chk1(pwr_en, 1'b1);
      chk1(zero_cmd, i != 0);
      chk1(tq_acc, i == 0);
      rchk(ADDR_EVT_STATUS, 32'h2, 32'h2);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      wt(4);
      wr(ADDR_EVT_STATUS, 32'hf);
    end
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    wt(6);
    chk1(phase_en, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    wt(6);
    chk1(phase_en, 1'b1);
    // Travel limits in position mode, forward then reverse
    wr(ADDR_CONFIG, 32'h1b9);
    for (int i = 0; i < 2; i++) begin
      pins(i != 0, i == 0, 1'b1, 1'b0);
      wt(6);
      chk1(mstop, 1'b1);
      chk1(i == 0 ? fwd_inh : rev_inh, 1'b1);
      rchk(ADDR_EVT_STATUS, 32'hc, 32'hc);
      wr(ADDR_LIMIT, 32'h3);
      wt(3);
      chk1(i == 0 ? fwd_inh : rev_inh, 1'b1);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      wt(6);
      chk1(i == 0 ? fwd_inh : rev_inh, 1'b1);
      wr(ADDR_LIMIT, 32'h3);
      wt(3);
      chk1(i == 0 ? fwd_inh : rev_inh, 1'b0);
      wr(ADDR_EVT_STATUS, 32'hf);
    end
    tally_and_finish();
  end
endmodule
